/* File: gain_stage.v */
// Purpose: digital coarse and fine gain on interleaved converter samples
// Assumes: one sample per clock tagged with lane and branch; registers written by serial control
// Notes  : samples are signed offset-free two's complement 8-bit
`timescale 1ns/10ps
`include "gain_defines.vh"
`default_nettype none
module gain_stage #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata_ff,
  output reg         reg_rvalid_ff,
  input  wire [1:0]  chan_mode,
  input  wire [7:0]  in_sample,
  input  wire [1:0]  in_lane,
  input  wire [2:0]  in_branch,
  input  wire        in_valid,
  output reg         in_ready_ff,
  output reg  [7:0]  out_sample_ff,
  output reg  [1:0]  out_lane_ff,
  output reg         out_valid_ff,
  input  wire        out_ready
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] quad_coarse_gain_codes_ff;
  reg [15:0] dual_single_coarse_gain_codes_ff;
  reg [15:0] gain_mode_config_ff;
  reg [15:0] fine_trim_ff [0:3];
  reg [15:0] nxt_rdata;

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      quad_coarse_gain_codes_ff        <= `RST_QUAD_COARSE;
      dual_single_coarse_gain_codes_ff <= `RST_DUAL_COARSE;
      gain_mode_config_ff              <= `RST_GAIN_MODE;
      fine_trim_ff[0] <= `RST_TRIM;
      fine_trim_ff[1] <= `RST_TRIM;
      fine_trim_ff[2] <= `RST_TRIM;
      fine_trim_ff[3] <= `RST_TRIM;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_QUAD_COARSE: quad_coarse_gain_codes_ff <= reg_wdata;
        `ADDR_DUAL_COARSE: dual_single_coarse_gain_codes_ff <= {4'h0, reg_wdata[11:0]};
        `ADDR_GAIN_MODE:   gain_mode_config_ff <= {14'h0000, reg_wdata[1:0]};
        `ADDR_TRIM_12:     fine_trim_ff[0] <= {1'b0, reg_wdata[14:8], 1'b0, reg_wdata[6:0]};
        `ADDR_TRIM_34:     fine_trim_ff[1] <= {1'b0, reg_wdata[14:8], 1'b0, reg_wdata[6:0]};
        `ADDR_TRIM_56:     fine_trim_ff[2] <= {1'b0, reg_wdata[14:8], 1'b0, reg_wdata[6:0]};
        `ADDR_TRIM_78:     fine_trim_ff[3] <= {1'b0, reg_wdata[14:8], 1'b0, reg_wdata[6:0]};
        default:           ;
      endcase
    end
  end

  always @*
  begin
    case (reg_addr)
      `ADDR_QUAD_COARSE: nxt_rdata = quad_coarse_gain_codes_ff;
      `ADDR_DUAL_COARSE: nxt_rdata = dual_single_coarse_gain_codes_ff;
      `ADDR_GAIN_MODE:   nxt_rdata = gain_mode_config_ff;
      `ADDR_TRIM_12:     nxt_rdata = fine_trim_ff[0];
      `ADDR_TRIM_34:     nxt_rdata = fine_trim_ff[1];
      `ADDR_TRIM_56:     nxt_rdata = fine_trim_ff[2];
      `ADDR_TRIM_78:     nxt_rdata = fine_trim_ff[3];
      default:           nxt_rdata = 16'h0000;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      reg_rdata_ff  <= 16'h0000;
      reg_rvalid_ff <= 1'b0;
    end
    else
    begin
      reg_rdata_ff  <= reg_rd ? nxt_rdata : reg_rdata_ff;
      reg_rvalid_ff <= reg_rd;
    end
  end

  // ----------------------------------------------------------------
  // code selection, captured with the sample
  // ----------------------------------------------------------------
  reg [3:0] coarse_code;
  reg [6:0] trim_code;
  wire      accept;

  assign accept = in_valid & in_ready_ff;

  always @*
  begin
    case (chan_mode)
      `MODE_QUAD: coarse_code = quad_coarse_gain_codes_ff[in_lane*4 +: 4];
      `MODE_DUAL: coarse_code = dual_single_coarse_gain_codes_ff[in_lane[0]*4 +: 4];
      default:    coarse_code = dual_single_coarse_gain_codes_ff[11:8];
    endcase
    // odd branch (1,3,5,7) lives in the low field
    trim_code = fine_trim_ff[in_branch[2:1]][in_branch[0]*8 +: 7];
  end

  // coarse gain as unsigned q6.8 multiplier; unused codes hold unity so output stays sane
  function [13:0] coarse_mult;
    input       scale_sel;
    input [3:0] code;
    begin
      if (scale_sel)
      begin
        case (code)
          4'h0: coarse_mult = 14'h0100;
          4'h1: coarse_mult = 14'h0140;
          4'h2: coarse_mult = 14'h0200;
          4'h3: coarse_mult = 14'h0280;
          4'h4: coarse_mult = 14'h0400;
          4'h5: coarse_mult = 14'h0500;
          4'h6: coarse_mult = 14'h0800;
          4'h7: coarse_mult = 14'h0a00;
          4'h8: coarse_mult = 14'h0c80;
          4'h9: coarse_mult = 14'h1000;
          4'ha: coarse_mult = 14'h1400;
          4'hb: coarse_mult = 14'h1900;
          4'hc: coarse_mult = 14'h2000;
          4'hd: coarse_mult = 14'h3200;
          default: coarse_mult = 14'h0100;
        endcase
      end
      else
      begin
        case (code)
          4'h0: coarse_mult = 14'h0100;
          4'h1: coarse_mult = 14'h011f;
          4'h2: coarse_mult = 14'h0143;
          4'h3: coarse_mult = 14'h016a;
          4'h4: coarse_mult = 14'h0196;
          4'h5: coarse_mult = 14'h01c7;
          4'h6: coarse_mult = 14'h01ff;
          4'h7: coarse_mult = 14'h023d;
          4'h8: coarse_mult = 14'h0282;
          4'h9: coarse_mult = 14'h02d0;
          4'ha: coarse_mult = 14'h0329;
          4'hb: coarse_mult = 14'h038c;
          4'hc: coarse_mult = 14'h03fb;
          default: coarse_mult = 14'h0100;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // stage 1: latch sample with its gain settings
  // ----------------------------------------------------------------
  reg signed [7:0] s1_sample_ff;
  reg [13:0]       s1_mult_ff;
  reg [6:0]        s1_trim_ff;
  reg              s1_fine_en_ff;
  reg [1:0]        s1_lane_ff;
  reg              s1_valid_ff;

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_sample_ff  <= 8'h00;
      s1_mult_ff    <= 14'h0100;
      s1_trim_ff    <= 7'h00;
      s1_fine_en_ff <= 1'b0;
      s1_lane_ff    <= 2'h0;
      s1_valid_ff   <= 1'b0;
    end
    else
    begin
      s1_valid_ff <= accept;
      if (accept)
      begin
        // settings captured per sample so a write never splits one sample
        s1_sample_ff  <= in_sample;
        s1_mult_ff    <= coarse_mult(gain_mode_config_ff[`BIT_SCALE_SEL], coarse_code);
        s1_trim_ff    <= trim_code;
        s1_fine_en_ff <= gain_mode_config_ff[`BIT_FINE_EN];
        s1_lane_ff    <= in_lane;
      end
    end
  end

  // ----------------------------------------------------------------
  // stage 2: fine trim then coarse gain, full precision
  // ----------------------------------------------------------------
  reg signed [14:0] trim_gain;
  reg signed [23:0] fine_prod;
  reg signed [38:0] full_prod;
  reg signed [16:0] scaled;
  reg [7:0]         nxt_out;

  always @*
  begin
    // ones-complement: negative codes are one above their two's value, so 7f and 00 both give unity
    if (!s1_fine_en_ff)
      trim_gain = 15'sh2000;
    else if (s1_trim_ff[6])
      trim_gain = 15'sh2000 + {{8{1'b1}}, s1_trim_ff} + 15'sh0001;
    else
      trim_gain = 15'sh2000 + {8'h00, s1_trim_ff};
    // keep all 13 trim fraction bits and 8 coarse fraction bits before rounding
    fine_prod = s1_sample_ff * trim_gain;
    full_prod = fine_prod * $signed({1'b0, s1_mult_ff});
    scaled    = full_prod[37:21] + {16'h0000, full_prod[20]};
  end

  // ----------------------------------------------------------------
  // saturation to the 8-bit output range
  // ----------------------------------------------------------------
  always @*
  begin
    if (scaled > 17'sd127)
      nxt_out = 8'h7f;
    else if (scaled < -17'sd128)
      nxt_out = 8'h80;
    else
      nxt_out = scaled[7:0];
  end

  // ----------------------------------------------------------------
  // output buffering
  // ----------------------------------------------------------------
  wire [9:0] fifo_out;
  wire       fifo_valid;
  wire       fifo_in_ready;
  wire       fifo_pop;

  sample_fifo #(
    .WIDTH (10),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   ({s1_lane_ff, nxt_out}),
    .in_valid  (s1_valid_ff),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign fifo_pop = fifo_valid & (~out_valid_ff | out_ready);

  // ----------------------------------------------------------------
  // input flow control
  // ----------------------------------------------------------------
  // ready is registered, so one more sample may arrive after it falls and one
  // may still sit in stage 1: keep three places free rather than drop a sample
  reg  [FIFO_AW+1:0] level_ff;
  wire [FIFO_AW+1:0] nxt_level;
  wire               room;

  assign nxt_level = level_ff + {{(FIFO_AW+1){1'b0}}, accept} - {{(FIFO_AW+1){1'b0}}, fifo_pop};
  assign room      = (level_ff + {{FIFO_AW{1'b0}}, 2'd3}) <= FIFO_DEPTH;

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      level_ff    <= {(FIFO_AW+2){1'b0}};
      in_ready_ff <= 1'b0;
    end
    else
    begin
      level_ff    <= nxt_level;
      in_ready_ff <= fifo_in_ready & room;
    end
  end

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      out_sample_ff <= 8'h00;
      out_lane_ff   <= 2'h0;
      out_valid_ff  <= 1'b0;
    end
    else
    begin
      if (fifo_pop)
      begin
        out_sample_ff <= fifo_out[7:0];
        out_lane_ff   <= fifo_out[9:8];
        out_valid_ff  <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid_ff <= 1'b0;
      end
    end
  end
endmodule // gain_stage
`default_nettype wire

/* File: gain_defines.vh */
// Purpose: constants for the digital coarse/fine gain stage
// Assumes: registers written by a simple address/data write port from the serial control logic
// Notes  : register offsets are the printed word addresses
//
// Summary of operation
// - each channel has its own four-bit coarse gain code
// - selector bit 0 means coarse codes are decibel steps
// - db codes 0..12 give 0..12 dB in 1 dB steps, higher codes unused
// - selector bit 1 means coarse codes are multiplicative factors
// - factor codes 0..13 give 1x through 50x, codes 14 and 15 unused
// - coarse path keeps more than eight bits internally
// - each converter branch has its own seven-bit fine trim code
// - fine trim only acts while the fine enable bit is 1
// - fine path keeps enough resolution that no codes go missing
// - quad lane codes sit in nibbles of register quad_coarse_gain_codes, lane1 lowest
// - register dual_single_coarse_gain_codes holds dual lanes in 3:0, 7:4 and single in 11:8
// - register gain_mode_config holds scale selector bit0, fine enable bit1, factor default
// - fine enable resets off, coarse codes reset to unity
// - registers fine_trim_branches_1_2..fine_trim_branches_7_8 hold odd trim in 6:0, even in 14:8
// - trim is ones-complement in 2^-13 units added to unity
`ifndef GAIN_DEFINES_VH
`define GAIN_DEFINES_VH
`define ADDR_QUAD_COARSE   8'h2a
`define ADDR_DUAL_COARSE   8'h2b
`define ADDR_GAIN_MODE     8'h33
`define ADDR_TRIM_12       8'h34
`define ADDR_TRIM_34       8'h35
`define ADDR_TRIM_56       8'h36
`define ADDR_TRIM_78       8'h37
`define RST_QUAD_COARSE    16'h0000
`define RST_DUAL_COARSE    16'h0000
`define RST_GAIN_MODE      16'h0001
`define RST_TRIM           16'h0000
`define BIT_SCALE_SEL      0
`define BIT_FINE_EN        1
`define MODE_SINGLE        2'h0
`define MODE_DUAL          2'h1
`define MODE_QUAD          2'h2
`define COARSE_FRAC        8
`define TRIM_FRAC          13
`endif

/* File: sample_fifo.v */
// Purpose: synchronous fifo between gain pipeline and output stage
// Assumes: single clock
// Notes  : depth must be a power of two
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_ff;
  reg [AW:0]      rd_ptr_ff;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty     = (wr_ptr_ff == rd_ptr_ff);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sample_fifo
`default_nettype wire

/* File: gain_checker.sv */
// Purpose: port-level assertions for gain_stage
// Assumes: one clock, synchronous active-low reset
// Notes  : bound onto every gain_stage instance
`timescale 1ns/10ps
`default_nettype none
module gain_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_rdata_ff,
  input wire logic        reg_rvalid_ff,
  input wire logic        in_valid,
  input wire logic        in_ready_ff,
  input wire logic [7:0]  out_sample_ff,
  input wire logic [1:0]  out_lane_ff,
  input wire logic        out_valid_ff,
  input wire logic        out_ready
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (reg_rd |=> reg_rvalid_ff)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (reg_rvalid_ff |-> $past(reg_rd))
    else $error("read valid without a read");
  a_mode_bits: assert property (reg_rd && reg_addr == 8'h33 |=> reg_rdata_ff[15:2] == 14'h0)
    else $error("mode register spare bits set");
  a_dual_bits: assert property (reg_rd && reg_addr == 8'h2b |=> reg_rdata_ff[15:12] == 4'h0)
    else $error("dual code register top nibble set");
  a_trim_bits: assert property (reg_rd && reg_addr inside {[8'h34:8'h37]}
    |=> !reg_rdata_ff[15] && !reg_rdata_ff[7])
    else $error("trim register spare bits set");
  a_stall_hold: assert property (out_valid_ff && !out_ready
    |=> out_valid_ff && $stable(out_sample_ff) && $stable(out_lane_ff))
    else $error("output changed while stalled");
  a_accept_out: assert property (in_valid && in_ready_ff |-> ##[3:64] out_valid_ff)
    else $error("accepted sample never reached output");
  a_reset_idle: assert property (disable iff (1'b0)
    !rst_b |=> !out_valid_ff && !in_ready_ff && !reg_rvalid_ff)
    else $error("outputs not idle in reset");
  a_ready_return: assert property ($rose(rst_b) |-> ##[1:3] in_ready_ff)
    else $error("ready did not return after reset");
  c_stall: cover property (out_valid_ff && !out_ready);
  c_full: cover property (in_valid && !in_ready_ff);
  c_read: cover property (reg_rvalid_ff);
endmodule // gain_checker
bind gain_stage gain_checker u_chk (.clk(clk), .rst_b(rst_b), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
  .in_valid(in_valid), .in_ready_ff(in_ready_ff), .out_sample_ff(out_sample_ff),
  .out_lane_ff(out_lane_ff), .out_valid_ff(out_valid_ff), .out_ready(out_ready));
`default_nettype wire

/* File: out_sink.sv */
// Purpose: stand-in for the serial output stage behind gain_stage
// Assumes: shares the sample clock
// Notes  : slow mode takes a sample every other cycle
`timescale 1ns/10ps
`default_nettype none
module out_sink (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic stall,
  input  wire logic slow,
  output var  logic out_ready
);
  // -----
  // ready
  // -----
  logic flip_ff;
  always @(posedge clk)
  begin
    flip_ff   <= rst_b & ~flip_ff;
    out_ready <= rst_b & ~stall & (~slow | flip_ff);
  end
endmodule // out_sink
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench for gain_stage
// Assumes: fifo shrunk to depth 4 so it fills quickly
// Notes  : expected codes worked out by hand from the gain tables
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [1:0] md; logic [1:0] ln; logic [2:0] br; logic [1:0] cfg;
    logic [3:0] cd; logic [6:0] tr; logic [7:0] s;  logic [7:0] e;
  } row_t;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] rdata;
  logic        rvalid;
  logic [1:0]  chan_mode = 2'h2;
  logic [7:0]  in_sample = 8'h00;
  logic [1:0]  in_lane = 2'h0;
  logic [2:0]  in_branch = 3'h0;
  logic        in_valid = 1'b0;
  logic        in_ready;
  logic [7:0]  out_sample;
  logic [1:0]  out_lane;
  logic        out_valid;
  logic        out_ready;
  logic        stall = 1'b0;
  logic        slow = 1'b0;
  logic        refused = 1'b0;
  logic [9:0]  got[$];
  int          errors = 0;
  int          cmp_count = 0;
  logic [23:0] mk[4] = '{24'h2b0fff, 24'h330003, 24'h367f7f, 24'h400000};
  // other lanes and the other trim field hold decoys so a wrong field shows
  row_t rows[17] = '{
    {2'h2,2'h0,3'h0,2'h1,4'h1,7'h00,8'h14,8'h19}, {2'h2,2'h3,3'h1,2'h1,4'hd,7'h00,8'h02,8'h64},
    {2'h2,2'h1,3'h2,2'h1,4'hd,7'h00,8'h03,8'h7f}, {2'h2,2'h2,3'h3,2'h1,4'hd,7'h00,8'hfd,8'h80},
    {2'h2,2'h0,3'h4,2'h0,4'h6,7'h00,8'h28,8'h50}, {2'h2,2'h0,3'h5,2'h0,4'hc,7'h00,8'h0a,8'h28},
    {2'h2,2'h0,3'h6,2'h0,4'hd,7'h00,8'h21,8'h21}, {2'h2,2'h0,3'h7,2'h1,4'he,7'h00,8'h21,8'h21},
    {2'h1,2'h1,3'h0,2'h1,4'h2,7'h00,8'h10,8'h20}, {2'h0,2'h0,3'h0,2'h1,4'h4,7'h00,8'h08,8'h20},
    {2'h2,2'h0,3'h0,2'h3,4'h0,7'h40,8'h7f,8'h7e}, {2'h2,2'h0,3'h0,2'h3,4'h0,7'h7f,8'h40,8'h40},
    {2'h2,2'h0,3'h0,2'h1,4'h0,7'h40,8'h7f,8'h7f}, {2'h2,2'h0,3'h1,2'h3,4'h0,7'h40,8'h7f,8'h7e},
    {2'h2,2'h0,3'h0,2'h2,4'h0,7'h00,8'h80,8'h80}, {2'h3,2'h2,3'h2,2'h1,4'h5,7'h00,8'h05,8'h19},
    {2'h2,2'h0,3'h5,2'h3,4'h0,7'h40,8'h7f,8'h7e}};
`define CHK(a, e) cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end
  always #2.5 clk = ~clk;
  gain_stage #(.FIFO_DEPTH(4), .FIFO_AW(2)) u_dut (.clk(clk), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid), .chan_mode(chan_mode),
    .in_sample(in_sample), .in_lane(in_lane), .in_branch(in_branch), .in_valid(in_valid),
    .in_ready_ff(in_ready), .out_sample_ff(out_sample), .out_lane_ff(out_lane),
    .out_valid_ff(out_valid), .out_ready(out_ready));
  out_sink u_sink (.clk(clk), .rst_b(rst_b), .stall(stall), .slow(slow), .out_ready(out_ready));
  always @(posedge clk)
  begin
    if (out_valid && out_ready) got.push_back({out_lane, out_sample});
    if (rst_b && in_valid && in_ready === 1'b0) refused <= 1'b1;
  end
  // -----
  // tasks
  // -----
  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK({rvalid, rdata}, {1'b1, e})
    @(posedge clk);
  endtask
  // ready is read at the falling edge, where it is settled for the next accept
  task automatic smp(input logic [1:0] l, input logic [2:0] b, input logic [7:0] s);
    in_lane <= l;
    in_branch <= b;
    in_sample <= s;
    in_valid <= 1'b1;
    @(negedge clk);
    while (in_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic expect_out(input logic [9:0] e);
    logic [9:0] v;
    repeat (60) if (got.size() == 0) @(posedge clk);
    v = (got.size() > 0) ? got.pop_front() : 10'h3ff;
    `CHK(v, e)
  endtask
  task automatic run_row(input row_t r);
    logic [1:0] nib;
    nib = (r.md == 2'h2) ? r.ln : ((r.md == 2'h1) ? {1'b0, r.ln[0]} : 2'h2);
    chan_mode <= r.md;
    wr(8'h33, {14'h0, r.cfg});
    wr((r.md == 2'h2) ? 8'h2a : 8'h2b, (16'h9999 & ~(16'hf << 4*nib)) | (16'(r.cd) << 4*nib));
    wr(8'h34 + 8'(r.br[2:1]), r.br[0] ? {1'b0, r.tr, 8'h3f} : {1'b0, 7'h3f, 1'b0, r.tr});
    smp(r.ln, r.br, r.s);
    in_valid <= 1'b0;
    expect_out({r.ln, r.e});
  endtask
  // --------
  // sequence
  // --------
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(8'h33, 16'h0001);
    rd(8'h2a, 16'h0000);
    rd(8'h2b, 16'h0000);
    for (int i = 0; i < 4; i++) rd(8'h34 + 8'(i), 16'h0000);
    foreach (rows[i]) run_row(rows[i]);
    for (int i = 0; i < 4; i++)
    begin
      wr(mk[i][23:16], 16'hffff);
      rd(mk[i][23:16], mk[i][15:0]);
    end
    // burst into a stalled sink, then drain it slowly
    wr(8'h33, 16'h0001);
    wr(8'h2a, 16'h0000);
    chan_mode <= 2'h2;
    stall <= 1'b1;
    fork
      begin
        repeat (30) @(posedge clk);
        stall <= 1'b0;
        slow <= 1'b1;
      end
      for (int i = 0; i < 8; i++) smp(2'(i), 3'h0, 8'(i));
    join
    in_valid <= 1'b0;
    `CHK(refused, 1'b1)
    for (int i = 0; i < 8; i++) expect_out({2'(i), 8'(i)});
    wr(8'h33, 16'h0003);
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(8'h33, 16'h0001);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
